// >>> rtl/pmp_top.sv
// PHY management poller: Wishbone registers, frame engine and PHY poll.
`timescale 1ns/1ps
`default_nettype none

module pmp_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic mdc_o,
   output logic mdio_o,
   output logic mdio_oe_o,
   input wire logic mdio_i
);
   import pmp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Byte-lane merge shared by the control, slot and select registers.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      return (old & ~m) | (nw & m);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Data line synchroniser; only the second stage is read by logic.
   logic mdi_s1_q;
   logic mdi_s2_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mdi_s1_q <= 1'b1;
         mdi_s2_q <= 1'b1;
      end else if (ce_i) begin
         mdi_s1_q <= mdio_i;
         mdi_s2_q <= mdi_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State.
   logic en_q, en_d, pre_q, pre_d;
   logic [15:0] div_q, div_d, dcnt_q, dcnt_d;
   logic [31:0] alive_q, alive_d, link_q, link_d;
   logic [1:0] lchg_q, lchg_d, done_q, done_d, mask_q, mask_d;
   pmp_slot_t slot_q [2];
   pmp_slot_t slot_d [2];
   pmp_psel_t psel_q [2];
   pmp_psel_t psel_d [2];
   pmp_state_t st_q, st_d;
   logic mdc_q, mdc_d, mdo_q, mdo_d, oe_q, oe_d;
   logic [63:0] sh_q, sh_d;
   logic [5:0] bit_q, bit_d;
   logic rd_q, rd_d, usr_q, usr_d, who_q, who_d, rr_q, rr_d, ack_q, ack_d;
   logic [4:0] poll_q, poll_d, phy_q, phy_d;
   logic [15:0] rdat_q, rdat_d;
   logic wb_ack_q, wb_ack_d;
   logic [31:0] wb_dat_q, wb_dat_d;

   logic tick, wb_hit, pick, newlink, rd_next;
   logic [31:0] rval;
   logic [63:0] frame;
   pmp_slot_t cur;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.
   always_comb begin
      en_d = en_q;
      pre_d = pre_q;
      div_d = div_q;
      alive_d = alive_q;
      link_d = link_q;
      lchg_d = lchg_q;
      done_d = done_q;
      mask_d = mask_q;
      slot_d = slot_q;
      psel_d = psel_q;
      st_d = st_q;
      mdc_d = mdc_q;
      mdo_d = mdo_q;
      oe_d = oe_q;
      sh_d = sh_q;
      bit_d = bit_q;
      rd_d = rd_q;
      usr_d = usr_q;
      who_d = who_q;
      rr_d = rr_q;
      ack_d = ack_q;
      poll_d = poll_q;
      phy_d = phy_q;
      rdat_d = rdat_q;
      pick = 1'b0;
      newlink = 1'b0;
      rd_next = 1'b0;
      cur = SLOT_RST;
      frame = '0;

      // Wishbone slave: one wait state, then a one-cycle ack.
      wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_q;
      wb_ack_d = wb_hit;
      case (wb_adr_i)
         OFS_CTRL: begin
            rval = 32'h0;
            rval[CTRL_EN_BIT] = en_q;
            rval[CTRL_PRE_BIT] = pre_q;
            rval[15:0] = div_q;
         end
         OFS_ALIVE: rval = alive_q;
         OFS_LINK: rval = link_q;
         OFS_LCHG_RAW: rval = {30'h0, lchg_q};
         OFS_LCHG_MSK: rval = {30'h0, lchg_q & {psel_q[1].irq_en, psel_q[0].irq_en}};
         OFS_DONE_RAW: rval = {30'h0, done_q};
         OFS_DONE_MSK: rval = {30'h0, done_q & mask_q};
         OFS_MASK_SET, OFS_MASK_CLR: rval = {30'h0, mask_q};
         OFS_SLOT0: rval = slot_q[0];
         OFS_SLOT1: rval = slot_q[1];
         OFS_PSEL0: rval = {26'h0, psel_q[0]};
         OFS_PSEL1: rval = {26'h0, psel_q[1]};
         default: rval = 32'h0;
      endcase
      wb_dat_d = wb_hit ? rval : wb_dat_q;

      if (wb_hit && wb_we_i) begin
         case (wb_adr_i)
            OFS_CTRL: begin
               rval = merge({1'b0, en_q, 9'h0, pre_q, 4'h0, div_q}, wb_dat_i, wb_sel_i);
               en_d = rval[CTRL_EN_BIT];
               pre_d = rval[CTRL_PRE_BIT];
               div_d = rval[15:0];
            end
            OFS_LCHG_RAW: lchg_d = lchg_q & ~(wb_dat_i[1:0] & {2{wb_sel_i[0]}});
            OFS_DONE_RAW: done_d = done_q & ~(wb_dat_i[1:0] & {2{wb_sel_i[0]}});
            OFS_MASK_SET: mask_d = mask_q | (wb_dat_i[1:0] & {2{wb_sel_i[0]}});
            OFS_MASK_CLR: mask_d = mask_q & ~(wb_dat_i[1:0] & {2{wb_sel_i[0]}});
            OFS_SLOT0: slot_d[0] = merge(slot_q[0], wb_dat_i, wb_sel_i);
            OFS_SLOT1: slot_d[1] = merge(slot_q[1], wb_dat_i, wb_sel_i);
            OFS_PSEL0: psel_d[0] = 6'(merge({26'h0, psel_q[0]}, wb_dat_i, wb_sel_i));
            OFS_PSEL1: psel_d[1] = 6'(merge({26'h0, psel_q[1]}, wb_dat_i, wb_sel_i));
            default: ;
         endcase
         slot_d[0].ack = slot_q[0].ack;
         slot_d[1].ack = slot_q[1].ack;
         slot_d[0].rsv = 3'h0;
         slot_d[1].rsv = 3'h0;
      end

      // Clock divider: one half period of the management clock per wrap.
      tick = (dcnt_q >= div_q);
      dcnt_d = (tick || !en_q) ? 16'h0 : dcnt_q + 16'h1;

      case (st_q)
         ST_IDLE: begin
            mdc_d = 1'b0;
            oe_d = 1'b0;
            if (en_q && tick) begin
               // Round robin: with both pending, serve the slot not served last.
               if (slot_q[0].go && slot_q[1].go) begin
                  pick = ~rr_q;
               end else begin
                  pick = slot_q[1].go;
               end
               if (slot_q[0].go || slot_q[1].go) begin
                  cur = slot_q[pick];
                  usr_d = 1'b1;
                  rr_d = pick;
               end else begin
                  cur.phy_adr = poll_q;
                  cur.reg_adr = STATUS_REG;
                  usr_d = 1'b0;
               end
               who_d = pick;
               rd_d = !cur.wr;
               phy_d = cur.phy_adr;
               frame = {PREAMBLE, SOF, cur.wr ? OP_WR : OP_RD, cur.phy_adr, cur.reg_adr,
                        TA_WR, cur.data};
               sh_d = pre_q ? frame : {frame[31:0], 32'h0};
               bit_d = pre_q ? 6'd0 : BIT_NOPRE;
               mdo_d = sh_d[63];
               oe_d = 1'b1;
               ack_d = 1'b0;
               rdat_d = 16'h0;
               st_d = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (!en_q) begin
               st_d = ST_IDLE;
               mdc_d = 1'b0;
               oe_d = 1'b0;
            end else if (tick && !mdc_q) begin
               mdc_d = 1'b1;
               if (rd_q && bit_q == BIT_TA1) begin
                  ack_d = !mdi_s2_q;
               end
               if (rd_q && bit_q > BIT_TA1) begin
                  rdat_d = {rdat_q[14:0], mdi_s2_q};
               end
            end else if (tick && bit_q == BIT_LAST) begin
               mdc_d = 1'b0;
               st_d = ST_FIN;
            end else if (tick) begin
               mdc_d = 1'b0;
               bit_d = bit_q + 6'd1;
               sh_d = {sh_q[62:0], 1'b0};
               mdo_d = sh_q[62];
               rd_next = rd_q && (bit_d >= BIT_TA0);
               oe_d = !rd_next;
            end
         end
         ST_FIN: begin
            // A write gives no answer, so only reads touch presence and link.
            st_d = ST_IDLE;
            mdc_d = 1'b0;
            oe_d = 1'b0;
            if (rd_q) begin
               alive_d[phy_q] = ack_q;
            end
            if (usr_q) begin
               slot_d[who_q].go = 1'b0;
               done_d[who_q] = 1'b1;
               if (rd_q) begin
                  slot_d[who_q].ack = ack_q;
                  slot_d[who_q].data = rdat_q;
               end
            end else begin
               newlink = ack_q && rdat_q[STATUS_LINK_BIT];
               link_d[phy_q] = newlink;
               for (int n = 0; n < 2; n++) begin
                  if (psel_q[n].phy_adr == phy_q && newlink != link_q[phy_q] &&
                      psel_q[n].irq_en) begin
                     lchg_d[n] = 1'b1;
                  end
               end
               poll_d = poll_q + 5'd1;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_q <= CTRL_EN_RST;
         pre_q <= CTRL_PRE_RST;
         div_q <= DIV_RST;
         dcnt_q <= 16'h0;
         alive_q <= 32'h0;
         link_q <= 32'h0;
         lchg_q <= 2'h0;
         done_q <= 2'h0;
         mask_q <= 2'h0;
         slot_q[0] <= SLOT_RST;
         slot_q[1] <= SLOT_RST;
         psel_q[0] <= PSEL_RST;
         psel_q[1] <= PSEL_RST;
         st_q <= ST_IDLE;
         mdc_q <= 1'b0;
         mdo_q <= 1'b0;
         oe_q <= 1'b0;
         sh_q <= 64'h0;
         bit_q <= 6'h0;
         rd_q <= 1'b0;
         usr_q <= 1'b0;
         who_q <= 1'b0;
         rr_q <= 1'b1;
         ack_q <= 1'b0;
         poll_q <= 5'h0;
         phy_q <= 5'h0;
         rdat_q <= 16'h0;
         wb_ack_q <= 1'b0;
         wb_dat_q <= 32'h0;
      end else if (ce_i) begin
         en_q <= en_d;
         pre_q <= pre_d;
         div_q <= div_d;
         dcnt_q <= dcnt_d;
         alive_q <= alive_d;
         link_q <= link_d;
         lchg_q <= lchg_d;
         done_q <= done_d;
         mask_q <= mask_d;
         slot_q <= slot_d;
         psel_q <= psel_d;
         st_q <= st_d;
         mdc_q <= mdc_d;
         mdo_q <= mdo_d;
         oe_q <= oe_d;
         sh_q <= sh_d;
         bit_q <= bit_d;
         rd_q <= rd_d;
         usr_q <= usr_d;
         who_q <= who_d;
         rr_q <= rr_d;
         ack_q <= ack_d;
         poll_q <= poll_d;
         phy_q <= phy_d;
         rdat_q <= rdat_d;
         wb_ack_q <= wb_ack_d;
         wb_dat_q <= wb_dat_d;
      end
   end

   assign wb_ack_o = wb_ack_q;
   assign wb_dat_o = wb_dat_q;
   assign mdc_o = mdc_q;
   assign mdio_o = mdo_q;
   assign mdio_oe_o = oe_q;

endmodule

`default_nettype wire

// >>> rtl/pmp_pkg.sv
// Constants, register map and carrier types of the PHY management poller.
package pmp_pkg;

   // Timing: the management clock must stay at or below its top rate.
   localparam int CLK_PERIOD_NS = 10;
   localparam int MDC_MIN_PERIOD_NS = 400;
   localparam int MDC_HALF_CYC = (MDC_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] DIV_RST = 16'(MDC_HALF_CYC - 1);

   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ALIVE = 8'h04;
   localparam logic [7:0] OFS_LINK = 8'h08;
   localparam logic [7:0] OFS_LCHG_RAW = 8'h0c;
   localparam logic [7:0] OFS_LCHG_MSK = 8'h10;
   localparam logic [7:0] OFS_DONE_RAW = 8'h14;
   localparam logic [7:0] OFS_DONE_MSK = 8'h18;
   localparam logic [7:0] OFS_MASK_SET = 8'h1c;
   localparam logic [7:0] OFS_MASK_CLR = 8'h20;
   localparam logic [7:0] OFS_SLOT0 = 8'h24;
   localparam logic [7:0] OFS_PSEL0 = 8'h28;
   localparam logic [7:0] OFS_SLOT1 = 8'h2c;
   localparam logic [7:0] OFS_PSEL1 = 8'h30;

   // Control register fields and reset values.
   localparam int CTRL_EN_BIT = 30;
   localparam int CTRL_PRE_BIT = 20;
   localparam logic CTRL_EN_RST = 1'b0;
   localparam logic CTRL_PRE_RST = 1'b1;

   // Frame layout, counted in bit positions of a 64-bit frame.
   localparam logic [31:0] PREAMBLE = 32'hffffffff;
   localparam logic [1:0] SOF = 2'b01;
   localparam logic [1:0] OP_RD = 2'b10;
   localparam logic [1:0] OP_WR = 2'b01;
   localparam logic [1:0] TA_WR = 2'b10;
   localparam logic [5:0] BIT_NOPRE = 6'd32;
   localparam logic [5:0] BIT_TA0 = 6'd46;
   localparam logic [5:0] BIT_TA1 = 6'd47;
   localparam logic [5:0] BIT_LAST = 6'd63;
   localparam logic [4:0] STATUS_REG = 5'h01;
   localparam int STATUS_LINK_BIT = 2;

   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_FIN} pmp_state_t;

   // One user request slot as software sees it.
   typedef struct packed {
      logic go;
      logic wr;
      logic ack;
      logic [2:0] rsv;
      logic [4:0] reg_adr;
      logic [4:0] phy_adr;
      logic [15:0] data;
   } pmp_slot_t;

   // Monitored PHY select: irq enable sits at bit 5 when read.
   typedef struct packed {
      logic irq_en;
      logic [4:0] phy_adr;
   } pmp_psel_t;

   localparam pmp_slot_t SLOT_RST = '0;
   localparam pmp_psel_t PSEL_RST = '0;

endpackage

// >>> verification/pmp_chk.sv
// Port checker for the PHY management poller.
`timescale 1ns/1ps
`default_nettype none
module pmp_chk
   import pmp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic mdc_o,
   input wire logic mdio_o,
   input wire logic mdio_oe_o,
   input wire logic mdio_i
);
   logic en_q;
   logic pre_q;
   logic [15:0] div_q;
   logic [16:0] hi_q;
   logic wr_ctl;
   ////////////////////////////////////////////////////////////////////////////////
   // The control shadow follows a write at its acknowledging edge, as software sees it.
   assign wr_ctl = ce_i && wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == OFS_CTRL;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_q <= CTRL_EN_RST;
         pre_q <= CTRL_PRE_RST;
         div_q <= DIV_RST;
         hi_q <= '0;
      end else begin
         hi_q <= mdc_o ? hi_q + 17'd1 : '0;
         if (wr_ctl && wb_sel_i[0]) div_q[7:0] <= wb_dat_i[7:0];
         if (wr_ctl && wb_sel_i[1]) div_q[15:8] <= wb_dat_i[15:8];
         if (wr_ctl && wb_sel_i[2]) pre_q <= wb_dat_i[CTRL_PRE_BIT];
         if (wr_ctl && wb_sel_i[3]) en_q <= wb_dat_i[CTRL_EN_BIT];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_pulse: assert property ($rose(wb_ack_o) |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
      else $error("request not answered on the next edge");
   chk_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without a request");
   chk_rdata_hold: assert property ($fell(wb_ack_o) |-> $stable(wb_dat_o))
      else $error("read data changed as ack fell");
   chk_idle_quiet: assert property ((!en_q) [*3] |-> !mdc_o && !mdio_oe_o)
      else $error("bus activity while disabled");
   chk_mdc_half: assert property ($fell(mdc_o) |-> hi_q == {1'b0, div_q} + 17'd1)
      else $error("management clock high phase has wrong length");
   chk_data_stable: assert property (mdio_oe_o && mdc_o && $past(mdc_o) |-> $stable(mdio_o))
      else $error("data changed while clock high");
   chk_frame_first: assert property ($rose(mdio_oe_o) |-> mdio_o == pre_q && !mdc_o)
      else $error("frame opened with wrong first bit");
   cover property (wb_ack_o && wb_we_i && wb_adr_i == OFS_SLOT0);
   cover property ($rose(mdio_oe_o) && mdio_o);
   cover property ($fell(mdio_oe_o) && !mdc_o);
endmodule
bind pmp_top pmp_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mdc_o(mdc_o),
   .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .mdio_i(mdio_i));
`default_nettype wire

// >>> verification/pmp_phy_model.sv
// Behavioural PHY answering management frames at one address.
`timescale 1ns/1ps
`default_nettype none
module pmp_phy_model
   import pmp_pkg::*;
#(
   parameter logic [4:0] PHY_ADR = 5'd5
) (
   input wire logic mdc_i,
   input wire logic mdio_i,
   input wire logic link_i,
   output logic mdio_o,
   output logic mdio_oe_o
);
   logic [5:0] cnt = '0;
   logic [14:0] sr = '0;
   logic [13:0] hdr = '0;
   logic [15:0] mem [32] = '{default: 16'h0};
   logic [15:0] rdat;
   logic rd;
   assign rd = hdr[11:10] == OP_RD && hdr[9:5] == PHY_ADR;
   assign rdat = (hdr[4:0] == STATUS_REG) ? 16'(link_i) << STATUS_LINK_BIT : mem[hdr[4:0]];
   initial begin
      mdio_o = 1'b1;
      mdio_oe_o = 1'b0;
   end
   // A frame opens on the first zero after idle ones, so the preamble is optional.
   always @(posedge mdc_i) begin
      sr <= {sr[13:0], mdio_i};
      if (cnt == 6'd0) begin
         if (mdio_i == 1'b0) cnt <= 6'd1;
      end else if (cnt == 6'd31) begin
         cnt <= 6'd0;
         if (hdr[11:10] == OP_WR && hdr[9:5] == PHY_ADR) mem[hdr[4:0]] <= {sr, mdio_i};
      end else begin
         cnt <= cnt + 6'd1;
         if (cnt == 6'd13) hdr <= {sr[12:0], mdio_i};
      end
   end
   // The first turnaround bit is left to the pull-up; the second is driven low.
   always @(negedge mdc_i) begin
      mdio_oe_o <= rd && cnt >= 6'd15;
      mdio_o <= (cnt == 6'd15) ? 1'b0 : rdat[4'(6'd31 - cnt)];
   end
endmodule
`default_nettype wire

// >>> verification/phy_management_poller_test.sv
// Self-checking bench for the PHY management poller.
`timescale 1ns/1ps
`default_nettype none
module phy_management_poller_test;
   import pmp_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic link = 1'b1;
   logic [7:0] adr = '0;
   logic [31:0] wdat = '0;
   logic [31:0] rdat;
   logic ack;
   logic mdc;
   logic mdo;
   logic moe;
   logic pho;
   logic phoe;
   wire line;
   int n_errors = 0;
   int n_compared = 0;
   // The shared data line has a pull-up, so a released line reads one.
   assign line = moe ? mdo : (phoe ? pho : 1'b1);
   initial begin
      forever #5 clk = ~clk;
   end
   pmp_top dut (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .mdc_o(mdc), .mdio_o(mdo), .mdio_oe_o(moe), .mdio_i(line));
   pmp_phy_model #(.PHY_ADR(5'd5)) phy (.mdc_i(mdc), .mdio_i(line), .link_i(link),
      .mdio_o(pho), .mdio_oe_o(phoe));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int i;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (ack === 1'b1) break;
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      chk("bus answer", 32'(i < 20), 32'h1);
      if (i == 20) test_done();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, '0, q);
      chk($sformatf("reg %h", a), q, e);
   endtask
   // Register polls are bounded; a full sweep of addresses fits well within the bound.
   task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      for (int i = 0; i < 8000; i++) begin
         wb(1'b0, a, '0, q);
         if ((q & m) === e) break;
      end
      chk($sformatf("wait %h", a), q & m, e);
      if ((q & m) !== e) test_done();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd_chk(OFS_CTRL, (32'(CTRL_PRE_RST) << CTRL_PRE_BIT) | 32'(DIV_RST));
      rd_chk(8'hfc, 32'h0);
      repeat (100) @(posedge clk);
      chk("clock idle", 32'(mdc), 32'h0);
      $display("test reset done");
      wr(OFS_CTRL, 32'h0000_0007);
      wr(OFS_CTRL, 32'h4000_0007);
      wait_reg(OFS_ALIVE, 32'hffff_ffff, 32'h20);
      rd_chk(OFS_LINK, 32'h20);
      $display("test poll done");
      wr(OFS_PSEL0, 32'h25);
      wr(OFS_PSEL1, 32'h05);
      link <= 1'b0;
      wait_reg(OFS_LINK, 32'hffff_ffff, 32'h0);
      rd_chk(OFS_LCHG_RAW, 32'h1);
      rd_chk(OFS_LCHG_MSK, 32'h1);
      wr(OFS_LCHG_RAW, 32'h1);
      rd_chk(OFS_LCHG_RAW, 32'h0);
      $display("test link change done");
      wr(OFS_MASK_SET, 32'h1);
      wr(OFS_SLOT0, 32'hc065_beef);
      wr(OFS_SLOT1, 32'h8065_0000);
      wait_reg(OFS_SLOT1, 32'h8000_0000, 32'h0);
      rd_chk(OFS_SLOT1, 32'h2065_beef);
      rd_chk(OFS_SLOT0, 32'h4065_beef);
      rd_chk(OFS_DONE_RAW, 32'h3);
      rd_chk(OFS_DONE_MSK, 32'h1);
      wr(OFS_MASK_CLR, 32'h1);
      rd_chk(OFS_DONE_MSK, 32'h0);
      wr(OFS_DONE_RAW, 32'h3);
      rd_chk(OFS_DONE_RAW, 32'h0);
      $display("test user slots done");
      wr(OFS_CTRL, 32'h4010_0007);
      wr(OFS_SLOT0, 32'h8069_0000);
      wr(OFS_SLOT1, 32'h8065_0000);
      wait_reg(OFS_SLOT0, 32'h8000_0000, 32'h0);
      wait_reg(OFS_SLOT1, 32'h8000_0000, 32'h0);
      rd_chk(OFS_SLOT0, 32'h0069_ffff);
      rd_chk(OFS_SLOT1, 32'h2065_beef);
      rd_chk(OFS_ALIVE, 32'h20);
      $display("test preamble and absent phy done");
      test_done();
   end
endmodule
`default_nettype wire
